/* File: core/fpbd_map.vh */
// constants shared by the function pin bank and its debounce filter
`ifndef FPBD_MAP_VH
`define FPBD_MAP_VH

// =========================================
// bank dimensions
`define FPBD_NPIN 40
`define FPBD_NPORT0 32
`define FPBD_NPORT1 8
`define FPBD_NTRIG 8
`define FPBD_NDSTAR 2
`define FPBD_NFILT 51
`define FPBD_NCTR 8
`define FPBD_NDEST 68
`define FPBD_NSRC 58
`define FPBD_NSRC_W 6'h3a
`define FPBD_NPIN_W 6'h28

// =========================================
// filter input slots
`define FPBD_FIDX_TRIG 40
`define FPBD_FIDX_STAR 48
`define FPBD_FIDX_DSTAR 49

// =========================================
// pin modes
`define FPBD_MODE_STATIC_IN 2'h0
`define FPBD_MODE_STATIC_OUT 2'h1
`define FPBD_MODE_TIMING_IN 2'h2
`define FPBD_MODE_TIMING_OUT 2'h3

// =========================================
// filter settings
`define FPBD_FILT_NONE 3'h0
`define FPBD_FILT_SHORT 3'h1
`define FPBD_FILT_MEDIUM 3'h2
`define FPBD_FILT_HIGH 3'h3
`define FPBD_FILT_CUSTOM 3'h4
`define FPBD_N_SHORT 10'h009
`define FPBD_N_MEDIUM 10'h200
`define FPBD_N_HIGH 10'h100
`define FPBD_N_MIN 10'h001

// =========================================
// filter timebases
`define FPBD_CLK_PERIOD_NS 10
`define FPBD_SLOW_PERIOD_NS 10000
// divider wraps after 1000 clocks, one slow tick per wrap
`define FPBD_SLOW_LAST 10'h3e7

// =========================================
// export source vector layout
`define FPBD_SRC_DIO 0
`define FPBD_SRC_OUT_SAMPLE 6'h04
`define FPBD_SRC_CTR 7
`define FPBD_SRC_FREQ 47
`define FPBD_SRC_STAR 48
`define FPBD_SRC_TRIG 49
`define FPBD_SRC_CHANGE 57

// =========================================
// routed destination layout
`define FPBD_DEST_PER_CTR 8
`define FPBD_DEST_IN_SAMPLE 64
`define FPBD_DEST_IN_TIMEBASE 65
`define FPBD_DEST_IN_REFTRIG 66
`define FPBD_DEST_OUT_SAMPLE 67

`endif

/* File: core/fpbd_filter.v */
// debounce filter for one input line
`timescale 1ns/100ps
`include "fpbd_map.vh"

module fpbd_filter (
   input wire clk_in,
   input wire rst_in,
   input wire raw_in,
   input wire [2:0] sel_in,
   input wire [9:0] custom_n_in,
   input wire custom_slow_in,
   input wire slow_tick_in,
   output reg filt_out
);

   reg [2:0] sel_r;
   reg [9:0] cnt_r;
   reg [9:0] need;
   reg tick;
   reg bypass;

   // =========================================
   // setting decode
   always @* begin
      need = `FPBD_N_MIN;
      tick = 1'b1;
      bypass = 1'b0;
      case (sel_r)
         `FPBD_FILT_SHORT: begin
            need = `FPBD_N_SHORT;
         end
         `FPBD_FILT_MEDIUM: begin
            need = `FPBD_N_MEDIUM;
         end
         `FPBD_FILT_HIGH: begin
            need = `FPBD_N_HIGH;
            tick = slow_tick_in;
         end
         `FPBD_FILT_CUSTOM: begin
            // n of zero is treated as one, the minimum count
            need = (custom_n_in == 10'h000) ? `FPBD_N_MIN : custom_n_in;
            tick = custom_slow_in ? slow_tick_in : 1'b1;
         end
         default: begin
            bypass = 1'b1;
         end
      endcase
   end

   // =========================================
   // sample counter
   always @(posedge clk_in) begin
      if (rst_in) begin
         sel_r <= `FPBD_FILT_NONE;
         cnt_r <= 10'h000;
         filt_out <= 1'b0;
      end else begin
         sel_r <= sel_in;
         if (bypass) begin
            // tracking raw keeps the level sane when a filter is switched on
            filt_out <= raw_in;
            cnt_r <= 10'h000;
         end else if (tick) begin
            if (raw_in == filt_out) begin
               cnt_r <= 10'h000;
            end else if ({1'b0, cnt_r} + 11'h001 >= {1'b0, need}) begin
               filt_out <= raw_in;
               cnt_r <= 10'h000;
            end else begin
               cnt_r <= cnt_r + 10'h001;
            end
         end
      end
   end

endmodule

/* File: core/fpbd_pin_bank.v */
// forty function pins with routing, change detection and debounce filters
// =========================================
// Overview of operation
// - forty pins, each input, output or timing
// - timing index 0-39, static via port bits
// - timing input pins route to counter and sampling destinations
// - routed inputs have polarity and edge/level choice
// - timing output pins drive any listed timing source
// - exported output sample strobe is inverted
// - per-pin change detection gives internal event
// - filters on pins, triggers, star, differential stars
// - enabled filter samples on filter clock edges
// - transition passes after N agreeing samples
// - none, short, medium, high, custom settings
// - every input keeps its own filter setting
// - all filters disabled after reset
// - filter jitter at most one timebase period
// - triggers forwarded to pins unfiltered
`timescale 1ns/100ps
`include "fpbd_map.vh"

module fpbd_pin_bank (
   input wire clk_in,
   input wire rst_in,
   // pads
   input wire [39:0] function_pin_in,
   output reg [39:0] function_pin_out,
   output reg [39:0] function_pin_oe_out,
   // per-pin configuration
   input wire [79:0] pin_mode_in,
   input wire [239:0] pin_src_sel_in,
   input wire [39:0] change_en_in,
   // static port access
   input wire [31:0] port_zero_bit_in,
   input wire [7:0] port_one_bit_in,
   output reg [31:0] port_zero_bit_out,
   output reg [7:0] port_one_bit_out,
   // backplane inputs
   input wire [7:0] backplane_trig_in,
   input wire backplane_star_in,
   input wire [1:0] diff_star_in,
   // filter configuration, one slot per filtered input
   input wire [152:0] filt_sel_in,
   input wire [509:0] filt_custom_n_in,
   input wire [50:0] filt_custom_slow_in,
   // internal timing sources for export
   input wire input_sample_strobe_in,
   input wire input_start_trigger_in,
   input wire input_reference_trigger_in,
   input wire input_pause_trigger_in,
   input wire output_sample_strobe_in,
   input wire output_start_trigger_in,
   input wire output_pause_trigger_in,
   input wire [7:0] ctr_source_in,
   input wire [7:0] ctr_gate_in,
   input wire [7:0] ctr_int_out_in,
   input wire [7:0] ctr_sample_in,
   input wire [7:0] ctr_arm_in,
   input wire freq_out_in,
   // routed destinations
   input wire [407:0] dest_sel_in,
   input wire [67:0] dest_pol_in,
   input wire [67:0] dest_edge_in,
   output reg [67:0] dest_out,
   // filtered backplane levels and change event
   output reg [7:0] backplane_trig_filt_out,
   output reg backplane_star_filt_out,
   output reg [1:0] diff_star_filt_out,
   output reg change_event_out
);

   // =========================================
   // mode decode
   function fn_is_input;
      input [1:0] mode;
      begin
         fn_is_input = (mode == `FPBD_MODE_STATIC_IN) || (mode == `FPBD_MODE_TIMING_IN);
      end
   endfunction

   function fn_is_output;
      input [1:0] mode;
      begin
         fn_is_output = (mode == `FPBD_MODE_STATIC_OUT) || (mode == `FPBD_MODE_TIMING_OUT);
      end
   endfunction

   function fn_is_timing_in;
      input [1:0] mode;
      begin
         fn_is_timing_in = (mode == `FPBD_MODE_TIMING_IN);
      end
   endfunction

   // out-of-range selects read as idle instead of wrapping
   function fn_sel_ok;
      input [5:0] sel;
      input [5:0] limit;
      begin
         fn_sel_ok = (sel < limit);
      end
   endfunction

   // =========================================
   // input synchronisers
   // every pad and backplane line is asynchronous to clk_in
   wire [50:0] raw_all;
   reg [50:0] sync1_r;
   reg [50:0] sync2_r;

   assign raw_all = {diff_star_in, backplane_star_in, backplane_trig_in, function_pin_in};

   always @(posedge clk_in) begin
      if (rst_in) begin
         sync1_r <= 51'h0;
         sync2_r <= 51'h0;
      end else begin
         sync1_r <= raw_all;
         sync2_r <= sync1_r;
      end
   end

   // =========================================
   // slow filter timebase
   // one shared tick keeps every slow filter sampling in step
   reg [9:0] div_r;
   reg slow_tick_r;

   always @(posedge clk_in) begin
      if (rst_in) begin
         div_r <= 10'h000;
         slow_tick_r <= 1'b0;
      end else if (div_r == `FPBD_SLOW_LAST) begin
         div_r <= 10'h000;
         slow_tick_r <= 1'b1;
      end else begin
         div_r <= div_r + 10'h001;
         slow_tick_r <= 1'b0;
      end
   end

   // =========================================
   // debounce filters
   wire [50:0] filt;

   genvar f;
   generate
      for (f = 0; f < `FPBD_NFILT; f = f + 1) begin : g_filt
         fpbd_filter u_filt (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .raw_in(sync2_r[f]),
            .sel_in(filt_sel_in[3*f +: 3]),
            .custom_n_in(filt_custom_n_in[10*f +: 10]),
            .custom_slow_in(filt_custom_slow_in[f]),
            .slow_tick_in(slow_tick_r),
            .filt_out(filt[f])
         );
      end
   endgenerate

   wire [39:0] pin_lvl;
   assign pin_lvl = filt[`FPBD_NPIN-1:0];

   // =========================================
   // change detection
   reg [39:0] pin_prev_r;
   wire [39:0] pin_changed;

   assign pin_changed = (pin_lvl ^ pin_prev_r) & change_en_in;

   always @(posedge clk_in) begin
      if (rst_in) begin
         pin_prev_r <= 40'h0;
         change_event_out <= 1'b0;
      end else begin
         pin_prev_r <= pin_lvl;
         change_event_out <= |pin_changed;
      end
   end

   // =========================================
   // export source vector
   wire [57:0] src_vec;

   // triggers come from the synchroniser, never the filter
   assign src_vec = {
      change_event_out,
      sync2_r[`FPBD_FIDX_TRIG +: `FPBD_NTRIG],
      filt[`FPBD_FIDX_STAR],
      freq_out_in,
      ctr_arm_in,
      ctr_sample_in,
      ctr_int_out_in,
      ctr_gate_in,
      ctr_source_in,
      output_pause_trigger_in,
      output_start_trigger_in,
      output_sample_strobe_in,
      input_pause_trigger_in,
      input_reference_trigger_in,
      input_start_trigger_in,
      input_sample_strobe_in
   };

   // =========================================
   // per-pin drive and static read
   // a static output drives its port bit, a timing output its selected source
   wire [39:0] static_val;
   wire [39:0] drive_nxt;
   wire [39:0] oe_nxt;
   wire [39:0] read_nxt;

   assign static_val = {port_one_bit_in, port_zero_bit_in};

   genvar p;
   generate
      for (p = 0; p < `FPBD_NPIN; p = p + 1) begin : g_pin
         wire [1:0] mode;
         wire [5:0] sel;
         wire src_bit;
         assign mode = pin_mode_in[2*p +: 2];
         assign sel = pin_src_sel_in[6*p +: 6];
         assign src_bit = fn_sel_ok(sel, `FPBD_NSRC_W) ?
            (src_vec[sel] ^ (sel == `FPBD_SRC_OUT_SAMPLE)) : 1'b0;
         assign drive_nxt[p] = (mode == `FPBD_MODE_STATIC_OUT) ? static_val[p] :
            ((mode == `FPBD_MODE_TIMING_OUT) ? src_bit : 1'b0);
         assign oe_nxt[p] = fn_is_output(mode);
         assign read_nxt[p] = fn_is_input(mode) & pin_lvl[p];
      end
   endgenerate

   always @(posedge clk_in) begin
      if (rst_in) begin
         function_pin_out <= 40'h0;
         function_pin_oe_out <= 40'h0;
         port_zero_bit_out <= 32'h0;
         port_one_bit_out <= 8'h0;
      end else begin
         function_pin_out <= drive_nxt;
         function_pin_oe_out <= oe_nxt;
         port_zero_bit_out <= read_nxt[`FPBD_NPORT0-1:0];
         port_one_bit_out <= read_nxt[`FPBD_NPIN-1:`FPBD_NPORT0];
      end
   end

   // =========================================
   // routed timing destinations
   wire [39:0] routable;
   wire [67:0] dest_lvl;
   reg [67:0] dest_prev_r;
   reg dest_armed_r;

   generate
      for (p = 0; p < `FPBD_NPIN; p = p + 1) begin : g_rt
         // static inputs stay off the timing fabric
         assign routable[p] = fn_is_timing_in(pin_mode_in[2*p +: 2]) & pin_lvl[p];
      end
   endgenerate

   genvar d;
   generate
      for (d = 0; d < `FPBD_NDEST; d = d + 1) begin : g_dest
         wire [5:0] psel;
         wire hit;
         assign psel = dest_sel_in[6*d +: 6];
         assign hit = fn_sel_ok(psel, `FPBD_NPIN_W) ? routable[psel] : 1'b0;
         assign dest_lvl[d] = hit ^ dest_pol_in[d];
      end
   endgenerate

   always @(posedge clk_in) begin
      if (rst_in) begin
         dest_prev_r <= 68'h0;
         dest_armed_r <= 1'b0;
         dest_out <= 68'h0;
      end else begin
         dest_prev_r <= dest_lvl;
         dest_armed_r <= 1'b1;
         // edge mode gives a one-cycle pulse on the active edge
         // an inverted idle level is no edge on the first cycle out of reset
         dest_out <= (dest_edge_in & dest_lvl & ~dest_prev_r & {`FPBD_NDEST{dest_armed_r}}) |
            (~dest_edge_in & dest_lvl);
      end
   end

   // =========================================
   // filtered backplane levels
   // these feed internal logic only; pins export the raw triggers
   always @(posedge clk_in) begin
      if (rst_in) begin
         backplane_trig_filt_out <= 8'h0;
         backplane_star_filt_out <= 1'b0;
         diff_star_filt_out <= 2'h0;
      end else begin
         backplane_trig_filt_out <= filt[`FPBD_FIDX_TRIG +: `FPBD_NTRIG];
         backplane_star_filt_out <= filt[`FPBD_FIDX_STAR];
         diff_star_filt_out <= filt[`FPBD_FIDX_DSTAR +: `FPBD_NDSTAR];
      end
   end

endmodule

/* File: test/fpbd_properties.sv */
// checker on the function pin bank ports
`timescale 1ns/100ps
module fpbd_properties (
   input wire clk_in,
   input wire rst_in,
   input wire [39:0] function_pin_in,
   input wire [39:0] function_pin_out,
   input wire [39:0] function_pin_oe_out,
   input wire [79:0] pin_mode_in,
   input wire [239:0] pin_src_sel_in,
   input wire [31:0] port_zero_bit_in,
   input wire [7:0] port_one_bit_in,
   input wire [31:0] port_zero_bit_out,
   input wire [152:0] filt_sel_in,
   input wire output_sample_strobe_in,
   input wire freq_out_in,
   input wire [67:0] dest_out,
   input wire change_event_out
);
   // =====
   // run of high samples on pad 0, saturates so it never wraps
   reg [3:0] hi_cnt_r;
   always @(posedge clk_in) begin
      if (rst_in || !function_pin_in[0])
         hi_cnt_r <= 4'h0;
      else if (hi_cnt_r != 4'hf)
         hi_cnt_r <= hi_cnt_r + 4'h1;
   end
   // =====
   // properties
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   a_oe_mode: assert property (
      1'b1 |=> function_pin_oe_out[0] == $past(pin_mode_in[0]))
      else $error("pin 0 enable wrong");
   a_static_out: assert property (
      pin_mode_in[1:0] == 2'h1 |=> function_pin_out[0] == $past(port_zero_bit_in[0]))
      else $error("pin 0 static value wrong");
   a_port_one: assert property (
      pin_mode_in[65:64] == 2'h1 |=> function_pin_out[32] == $past(port_one_bit_in[0]))
      else $error("pin 32 static value wrong");
   a_out_invert: assert property (
      pin_mode_in[1:0] == 2'h3 && pin_src_sel_in[5:0] == 6'h04
      |=> function_pin_out[0] != $past(output_sample_strobe_in))
      else $error("output strobe not inverted");
   a_freq_export: assert property (
      pin_mode_in[1:0] == 2'h3 && pin_src_sel_in[5:0] == 6'h2f
      |=> function_pin_out[0] == $past(freq_out_in))
      else $error("frequency output not exported");
   a_reset_idle: assert property (disable iff (1'b0)
      rst_in |=> function_pin_oe_out == 40'h0 && dest_out == 68'h0 && !change_event_out)
      else $error("outputs active after reset");
   a_bypass_delay: assert property (
      filt_sel_in[5:3] == 3'h0 && $past(pin_mode_in[3:2]) == 2'h0
      |-> port_zero_bit_out[1] == $past(function_pin_in[1], 4))
      else $error("unfiltered pin 1 latency wrong");
   a_short_filter: assert property (
      $rose(port_zero_bit_out[0]) && filt_sel_in[2:0] == 3'h1 && pin_mode_in[1:0] == 2'h0
      |-> $past(hi_cnt_r, 3) >= 4'h9)
      else $error("short filter passed too early");
endmodule

bind fpbd_pin_bank fpbd_properties i_fpbd_properties (
   .clk_in(clk_in), .rst_in(rst_in), .function_pin_in(function_pin_in),
   .function_pin_out(function_pin_out), .function_pin_oe_out(function_pin_oe_out),
   .pin_mode_in(pin_mode_in), .pin_src_sel_in(pin_src_sel_in),
   .port_zero_bit_in(port_zero_bit_in), .port_one_bit_in(port_one_bit_in),
   .port_zero_bit_out(port_zero_bit_out), .filt_sel_in(filt_sel_in),
   .output_sample_strobe_in(output_sample_strobe_in), .freq_out_in(freq_out_in),
   .dest_out(dest_out), .change_event_out(change_event_out));

/* File: test/fpbd_far_side.sv */
// far-side wiring model: pads, backplane triggers and stars
`timescale 1ns/100ps
module fpbd_far_side (
   input wire clk_in,
   output reg [39:0] pad_out,
   output reg [7:0] trig_out,
   output reg star_out,
   output reg [1:0] dstar_out
);
   // =====
   // lines move just after an edge; a glitch is simply a short hold
   initial begin
      pad_out = 40'h0;
      trig_out = 8'h0;
      star_out = 1'b0;
      dstar_out = 2'h0;
   end
   task drive_pad(input integer idx, input val, input integer hold);
      begin
         @(posedge clk_in);
         pad_out[idx] <= val;
         repeat (hold) @(posedge clk_in);
      end
   endtask
   task drive_bp(input [10:0] val, input integer hold);
      begin
         @(posedge clk_in);
         {dstar_out, star_out, trig_out} <= val;
         repeat (hold) @(posedge clk_in);
      end
   endtask
endmodule

/* File: test/testbench.sv */
// self-checking bench for the function pin bank
`timescale 1ns/100ps
module testbench;
   reg clk_in;
   reg rst_in;
   reg [79:0] pin_mode;
   reg [239:0] src_sel;
   reg [39:0] chg_en;
   reg [31:0] p0;
   reg [7:0] p1;
   reg [152:0] fsel;
   reg [509:0] fn;
   reg [50:0] fslow;
   reg [47:0] srcs;
   reg [407:0] dsel;
   reg [67:0] dpol;
   reg [67:0] dedge;
   wire [39:0] pin_out, pin_oe, pad_lvl, pin_lvl;
   wire [31:0] p0_out;
   wire [7:0] p1_out, trig, trig_f;
   wire [1:0] dstar, dstar_f;
   wire star, star_f, chg;
   wire [67:0] dest;
   integer mismatches, total_checks, n;
   // =====
   // wire level: the bank wins where it drives
   assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & pad_lvl);
   fpbd_far_side i_fpbd_far_side (.clk_in(clk_in), .pad_out(pad_lvl), .trig_out(trig),
      .star_out(star), .dstar_out(dstar));
   fpbd_pin_bank i_fpbd_pin_bank (
      .clk_in(clk_in), .rst_in(rst_in), .function_pin_in(pin_lvl),
      .function_pin_out(pin_out), .function_pin_oe_out(pin_oe), .pin_mode_in(pin_mode),
      .pin_src_sel_in(src_sel), .change_en_in(chg_en), .port_zero_bit_in(p0),
      .port_one_bit_in(p1), .port_zero_bit_out(p0_out), .port_one_bit_out(p1_out),
      .backplane_trig_in(trig), .backplane_star_in(star), .diff_star_in(dstar),
      .filt_sel_in(fsel), .filt_custom_n_in(fn), .filt_custom_slow_in(fslow),
      .input_sample_strobe_in(srcs[0]), .input_start_trigger_in(srcs[1]),
      .input_reference_trigger_in(srcs[2]), .input_pause_trigger_in(srcs[3]),
      .output_sample_strobe_in(srcs[4]), .output_start_trigger_in(srcs[5]),
      .output_pause_trigger_in(srcs[6]), .ctr_source_in(srcs[14:7]),
      .ctr_gate_in(srcs[22:15]), .ctr_int_out_in(srcs[30:23]),
      .ctr_sample_in(srcs[38:31]), .ctr_arm_in(srcs[46:39]), .freq_out_in(srcs[47]),
      .dest_sel_in(dsel), .dest_pol_in(dpol), .dest_edge_in(dedge), .dest_out(dest),
      .backplane_trig_filt_out(trig_f), .backplane_star_filt_out(star_f),
      .diff_star_filt_out(dstar_f), .change_event_out(chg));
   // =====
   // helpers
   task tick(input integer c);
      begin
         repeat (c) @(posedge clk_in);
         #1;
      end
   endtask
   task check(input [67:0] got, input [67:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task pad(input integer idx, input val, input integer hold);
      i_fpbd_far_side.drive_pad(idx, val, hold);
   endtask
   task lat(input integer pin);
      begin
         n = 0;
         pad(pin, 1'b1, 0);
         while (p0_out[pin] !== 1'b1 && n < 1100) begin
            tick(1);
            n = n + 1;
         end
      end
   endtask
   task complete_run;
      begin
         if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   // =====
   // scenarios
   task t_filters;
      integer k;
      begin
         lat(2);
         check(n, 4);
         for (k = 0; k < 4; k = k + 1) begin
            @(posedge clk_in);
            fsel[8:6] <= (k == 3) ? 3'h4 : k[2:0];
            fn[29:20] <= 10'h005;
            pad(2, 1'b0, 600);
            tick(1);
            check(p0_out[2], 1'b0);
            lat(2);
            check(n, (k == 0) ? 4 : (k == 1) ? 12 : (k == 2) ? 515 : 8);
         end
         @(posedge clk_in);
         fslow[2] <= 1'b1;
         fn[29:20] <= 10'h000;
         pad(2, 1'b0, 1100);
         lat(2);
         check(n >= 4 && n <= 1004, 1'b1);
         @(posedge clk_in);
         fsel[8:6] <= 3'h3;
         pad(2, 1'b0, 300);
         pad(2, 1'b1, 0);
         tick(0);
         check(p0_out[2], 1'b1);
      end
   endtask
   task t_glitch;
      begin
         @(posedge clk_in);
         fsel[2:0] <= 3'h1;
         pad(1, 1'b1, 0);
         pad(0, 1'b1, 7);
         pad(0, 1'b0, 20);
         tick(0);
         check(p0_out[1:0], 2'b10);
         pad(0, 1'b1, 8);
         pad(0, 1'b0, 1);
         tick(3);
         check(p0_out[0], 1'b1);
         tick(20);
         check(p0_out[0], 1'b0);
      end
   endtask
   task t_static;
      begin
         @(posedge clk_in);
         pin_mode <= {40{2'h1}};
         p0 <= 32'ha5c30f96;
         p1 <= 8'h69;
         tick(2);
         check(pin_out, 40'h69a5c30f96);
         check(pin_oe, {40{1'b1}});
         check({p1_out, p0_out}, 40'h0);
         @(posedge clk_in);
         pin_mode <= 80'h0;
         pad(39, 1'b1, 0);
         tick(5);
         check({pin_oe, p1_out[7]}, 41'h1);
      end
   endtask
   task t_route;
      begin
         @(posedge clk_in);
         pin_mode[7:6] <= 2'h2;
         dsel[5:0] <= 6'h03;
         dsel[407:402] <= 6'h03;
         dpol[67] <= 1'b1;
         chg_en[3] <= 1'b1;
         tick(5);
         check({dest[67], dest[0]}, 2'b10);
         pad(3, 1'b1, 0);
         tick(4);
         check({chg, dest[67], dest[0]}, 3'b101);
         tick(1);
         check(chg, 1'b0);
         @(posedge clk_in);
         dedge[0] <= 1'b1;
         pad(3, 1'b0, 10);
         pad(3, 1'b1, 0);
         tick(4);
         check(dest[0], 1'b1);
         tick(1);
         check(dest[0], 1'b0);
         @(posedge clk_in);
         pin_mode[7:6] <= 2'h0;
         tick(3);
         check(dest[67], 1'b1);
      end
   endtask
   task t_export;
      integer k;
      begin
         @(posedge clk_in);
         pin_mode[1:0] <= 2'h3;
         for (k = 0; k < 48; k = k + 1) begin
            @(posedge clk_in);
            src_sel[5:0] <= k[5:0];
            srcs <= 48'h1 << k;
            tick(1);
            check(pin_out[0], k != 4);
            @(posedge clk_in);
            srcs <= ~(48'h1 << k);
            tick(1);
            check(pin_out[0], k == 4);
         end
         @(posedge clk_in);
         src_sel[5:0] <= 6'h31;
         fsel[122:120] <= 3'h3;
         i_fpbd_far_side.drive_bp(11'h701, 20);
         tick(0);
         check({trig_f[0], pin_out[0]}, 2'b01);
         check({dstar_f, star_f}, 3'h7);
         @(posedge clk_in);
         src_sel[5:0] <= 6'h30;
         tick(2);
         check(pin_out[0], 1'b1);
         @(posedge clk_in);
         src_sel[5:0] <= 6'h39;
         pad(3, 1'b0, 0);
         tick(5);
         check(pin_out[0], 1'b1);
         tick(1);
         check(pin_out[0], 1'b0);
         @(posedge clk_in);
         src_sel[5:0] <= 6'h3f;
         srcs <= {48{1'b1}};
         tick(2);
         check(pin_out[0], 1'b0);
      end
   endtask
   // =====
   // clock, watchdog and main sequence
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      mismatches = mismatches + 1;
      complete_run;
   end
   initial begin
      mismatches = 0;
      total_checks = 0;
      rst_in = 1'b1;
      pin_mode = 80'h0;
      src_sel = 240'h0;
      chg_en = 40'h0;
      p0 = 32'h0;
      p1 = 8'h0;
      fsel = 153'h0;
      fn = 510'h0;
      fslow = 51'h0;
      srcs = 48'h0;
      dsel = {408{1'b1}};
      dpol = 68'h0;
      dedge = 68'h0;
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      t_filters;
      t_glitch;
      t_static;
      t_route;
      t_export;
      complete_run;
   end
endmodule
